// ---- tmr8_pkg.sv ----
// Purpose: Shared constants and types for the 8-bit waveform timer.
// Assumes: Register indices are word indices; byte address = 4 * index.
// Notes:   All field positions, reset values and prescale masks live here.

package tmr8_pkg;

    // ************************************************
    // Register word indices (haddr[9:2])
    // ************************************************
    localparam logic [7:0] TMR8_IDX_CTRLA = 8'h24;
    localparam logic [7:0] TMR8_IDX_CTRLB = 8'h25;
    localparam logic [7:0] TMR8_IDX_COUNT = 8'h26;
    localparam logic [7:0] TMR8_IDX_CMPA  = 8'h27;
    localparam logic [7:0] TMR8_IDX_PIN   = 8'h28;
    localparam logic [7:0] TMR8_IDX_FLAGS = 8'h15;

    // ************************************************
    // Field positions
    // ************************************************
    localparam int TMR8_CTRLA_COM_LO = 6;
    localparam int TMR8_CTRLA_WGM_LO = 0;
    localparam int TMR8_CTRLB_WGM_HI = 3;
    localparam int TMR8_CTRLB_CS_LO  = 0;
    localparam int TMR8_FLAG_OVF     = 0;
    localparam int TMR8_FLAG_MATCH   = 1;
    localparam int TMR8_PIN_DATA     = 0;
    localparam int TMR8_PIN_DIR      = 1;

    // ************************************************
    // Values
    // ************************************************
    localparam logic [7:0] TMR8_MAX    = 8'hFF;
    localparam logic [7:0] TMR8_BOTTOM = 8'h00;
    localparam logic [7:0] TMR8_REG_RESET = 8'h00;

    // Waveform mode codes
    localparam logic [2:0] TMR8_MODE_NORMAL = 3'h0;
    localparam logic [2:0] TMR8_MODE_PC_MAX = 3'h1;
    localparam logic [2:0] TMR8_MODE_CTC    = 3'h2;
    localparam logic [2:0] TMR8_MODE_FP_MAX = 3'h3;
    localparam logic [2:0] TMR8_MODE_PC_CMP = 3'h5;
    localparam logic [2:0] TMR8_MODE_FP_CMP = 3'h7;

    // Clock select codes and prescaler masks (tick when low bits all ones)
    localparam logic [2:0] TMR8_CS_DIV1    = 3'h1;
    localparam logic [2:0] TMR8_CS_DIV8    = 3'h2;
    localparam logic [2:0] TMR8_CS_DIV64   = 3'h3;
    localparam logic [2:0] TMR8_CS_DIV256  = 3'h4;
    localparam logic [2:0] TMR8_CS_DIV1024 = 3'h5;
    localparam logic [9:0] TMR8_PRE_M8     = 10'h007;
    localparam logic [9:0] TMR8_PRE_M64    = 10'h03F;
    localparam logic [9:0] TMR8_PRE_M256   = 10'h0FF;
    localparam logic [9:0] TMR8_PRE_M1024  = 10'h3FF;

    // ************************************************
    // Types
    // ************************************************
    typedef struct packed {
        logic out;  // Level driven onto the pin
        logic oe;   // Pin driver enable
    } tmr8_pin_t;

    typedef struct packed {
        logic [1:0]  com;
        logic [1:0]  wgmLow;
        logic        wgmHigh;
        logic [2:0]  clkSel;
        logic [7:0]  cnt;
        logic        cntDown;
        logic [7:0]  ocrBuf;
        logic [7:0]  ocrAct;
        logic        oc;
        logic        ovfFlag;
        logic        matchFlag;
        logic        blockMatch;
        logic [9:0]  pre;
        logic        pinData;
        logic        pinDir;
        logic        pinOut;
        logic        apValid;
        logic        apWrite;
        logic [7:0]  apIdx;
        logic [31:0] rdata;
    } tmr8_state_t;

endpackage : tmr8_pkg

// ---- tmr8_wave_timer.sv ----
// Purpose: 8-bit timer/counter with waveform generation on compare output A.
// Assumes: Single 200 MHz clock; AHB-Lite slave, zero wait states.
// Notes:   Read data is captured in the address phase of a read.
//
// What this block does
// R01 - Modes 1 and 5 count up to TOP then down to bottom, repeating.
// R02 - Phase correct TOP is 0xFF in mode 1, compare A in mode 5.
// R03 - Phase correct non-inverting: clear on up match, set on down match.
// R04 - Counter holds TOP for one tick, then counts down.
// R05 - Phase correct sets the overflow flag each time bottom is reached.
// R06 - Phase correct: code 2 normal PWM, 3 inverted, 1 toggles only if high mode bit.
// R07 - Compare at bottom gives steady low, at MAX steady high (non-inverted).
// R08 - Output forced at bottom for symmetry when a match was missed or changed.
// R09 - Phase correct with TOP 0xFF has a 510-tick period.
// R10 - Timer tick is the clock divided by 1, 8, 64, 256 or 1024.
// R11 - Tick is a clock enable on the single clock; flags set with it.
// R12 - Nonzero output mode takes the pin over, except toggle code in PWM without high mode bit; driver enabled by direction bit.
// R13 - Non-PWM output mode: disconnect, toggle, clear or set on match.
// R14 - Fast PWM: code 2 clears on match sets at bottom; code 3 opposite.
// R15 - Fast PWM with compare at TOP ignores match, acts at bottom.
// R16 - Phase correct with compare at TOP ignores match, acts at TOP.
// R17 - Three-bit mode decodes normal, phase correct, CLEAR_ON_MATCH_MODE, fast PWM; 4 and 6 reserved.
// R18 - Compare loads at once in normal and CLEAR_ON_MATCH_MODE, only at TOP in PWM.
// R19 - Overflow at MAX in 0, 2, 3; at bottom in 1, 5; at TOP in 7.
// R20 - Unused control A bits between the fields read as zero.
// R21 - High mode bit sits at bit 3 of control B and joins the low bits.
//
// Decided for this implementation: the AHB-Lite slave port.

`timescale 1ns/100ps

module tmr8_wave_timer
    import tmr8_pkg::*;
(
    input  wire logic        clk,        // 200 MHz clock
    input  wire logic        reset,      // Async reset, active high
    input  wire logic        hsel,       // AHB slave select
    input  wire logic [31:0] haddr,      // AHB address
    input  wire logic [1:0]  htrans,     // AHB transfer type
    input  wire logic        hwrite,     // AHB write
    input  wire logic [2:0]  hsize,      // AHB size, word only
    input  wire logic        hready,     // AHB ready in
    input  wire logic [31:0] hwdata,     // AHB write data
    output logic      [31:0] hrdata,     // AHB read data
    output logic             hreadyout,  // AHB ready out
    output logic             hresp,      // AHB response, always OKAY
    output tmr8_pin_t        pin         // Pin level and driver enable
);

    // ************************************************
    // State
    // ************************************************
    tmr8_state_t s_r;
    tmr8_state_t s_nxt;

    logic [2:0] mode;
    logic       isPc;
    logic       isFast;
    logic       isPwm;
    logic       ocrIsTop;
    logic [7:0] top;
    logic       tick;
    logic       atTop;
    logic       atBot;
    logic       match;
    logic       busWr;
    logic [7:0] wd;
    logic       connected;

    // Register read mux, reserved bits zero
    function automatic logic [31:0] readReg(input logic [7:0] idx, input tmr8_state_t s);
        logic [7:0] v;
        v = 8'h00;
        case (idx)
            TMR8_IDX_CTRLA: v = {s.com, 4'h0, s.wgmLow};           // [R20]
            TMR8_IDX_CTRLB: v = {4'h0, s.wgmHigh, s.clkSel};       // [R21]
            TMR8_IDX_COUNT: v = s.cnt;
            TMR8_IDX_CMPA:  v = s.ocrBuf;
            TMR8_IDX_FLAGS: v = {6'h00, s.matchFlag, s.ovfFlag};
            TMR8_IDX_PIN:   v = {6'h00, s.pinDir, s.pinData};
            default:        v = 8'h00;
        endcase
        return {24'h000000, v};
    endfunction : readReg

    // ************************************************
    // Mode decode
    // ************************************************

    // Three-bit mode from both control registers
    always_comb
    begin
        mode     = {s_r.wgmHigh, s_r.wgmLow};                       // [R21]
        isPc     = (mode == TMR8_MODE_PC_MAX) || (mode == TMR8_MODE_PC_CMP);   // [R01] [R17]
        isFast   = (mode == TMR8_MODE_FP_MAX) || (mode == TMR8_MODE_FP_CMP);   // [R17]
        isPwm    = isPc || isFast;
        ocrIsTop = (mode == TMR8_MODE_CTC) || (mode == TMR8_MODE_PC_CMP)
                   || (mode == TMR8_MODE_FP_CMP);
        top      = ocrIsTop ? s_r.ocrAct : TMR8_MAX;                // [R02] [R17]
        atTop    = (s_r.cnt == top);
        atBot    = (s_r.cnt == TMR8_BOTTOM);
        match    = (s_r.cnt == s_r.ocrAct) && !s_r.blockMatch;
    end

    // ************************************************
    // Prescaler tick
    // ************************************************

    // Tick is an enable, never a clock, so all logic stays on clk
    // Masks test only the low prescaler bits, so one counter serves
    // every division; a new select may give a short first tick period.
    // Reserved select codes stop the timer rather than guess a rate.
    always_comb
    begin
        case (s_r.clkSel)                                           // [R10] [R11]
            TMR8_CS_DIV1:    tick = 1'b1;
            TMR8_CS_DIV8:    tick = (s_r.pre & TMR8_PRE_M8) == TMR8_PRE_M8;
            TMR8_CS_DIV64:   tick = (s_r.pre & TMR8_PRE_M64) == TMR8_PRE_M64;
            TMR8_CS_DIV256:  tick = (s_r.pre & TMR8_PRE_M256) == TMR8_PRE_M256;
            TMR8_CS_DIV1024: tick = (s_r.pre & TMR8_PRE_M1024) == TMR8_PRE_M1024;
            default:         tick = 1'b0;                           // Stopped or reserved
        endcase
    end

    // ************************************************
    // Next state
    // ************************************************

    // Order of work inside this process matters:
    //   1. Prescaler advances every cycle while selected
    //   2. Flag clears from the bus are applied first
    //   3. Tick-driven counting, flags and waveform follow,
    //      so a hardware set wins over a software clear
    //   4. Register writes follow them and beat the tick,
    //      so software always sees what it wrote
    //   5. Address phase capture and pin takeover close it
    //
    // Counting
    //   Phase correct runs 0 up to TOP and back down to 0.
    //   TOP and bottom each show for exactly one tick.
    //   Single slope modes wrap from TOP to bottom.
    //   A TOP lowered below the count lets it run to MAX.
    //
    // Compare output
    //   Non-PWM modes act only on a match.
    //   Fast PWM acts on the match and on the wrap from TOP.
    //   Phase correct acts on the up and down matches, and
    //   forces the down-match level at bottom to stay
    //   symmetric when a match was skipped.
    //
    // Compare buffer
    //   Writes land in the buffer at once; the active
    //   comparator takes them at once outside PWM, and at
    //   TOP in PWM to avoid glitched pulses mid-period.
    //
    // Limitation: a counter write while running may skip a
    // match; the blocked match only covers the next tick.
    //
    // Pin
    //   Output mode zero hands the pin to the data bit.
    //   Toggle code in PWM without the high mode bit also
    //   leaves the pin to the data bit.
    //   The driver enable is the direction bit alone.
    always_comb
    begin
        s_nxt = s_r;
        busWr = s_r.apValid && s_r.apWrite;
        wd    = hwdata[7:0];

        // Free-running prescaler; stopped timer keeps it at zero
        s_nxt.pre = (s_r.clkSel == 3'h0) ? 10'h000 : s_r.pre + 10'h001;

        // Flag clears by writing one; a set below still wins
        if (busWr && s_r.apIdx == TMR8_IDX_FLAGS)
        begin
            if (wd[TMR8_FLAG_OVF])
                s_nxt.ovfFlag = 1'b0;
            if (wd[TMR8_FLAG_MATCH])
                s_nxt.matchFlag = 1'b0;
        end

        // Counting on each timer tick
        if (tick)
        begin
            s_nxt.blockMatch = 1'b0;
            if (isPc)
            begin
                if (!s_r.cntDown)
                begin
                    if (atTop)
                    begin
                        // TOP shows for this one tick, then the slope turns
                        s_nxt.cntDown = 1'b1;                       // [R04] [R01]
                        s_nxt.cnt     = (top == TMR8_BOTTOM) ? s_r.cnt : s_r.cnt - 8'h01;
                    end
                    else
                        s_nxt.cnt = s_r.cnt + 8'h01;
                end
                else if (atBot)
                begin
                    // Bottom is held one tick: 255 up plus 255 down = 510
                    s_nxt.cntDown = 1'b0;                           // [R09]
                    s_nxt.cnt     = (top == TMR8_BOTTOM) ? s_r.cnt : s_r.cnt + 8'h01;
                end
                else
                    s_nxt.cnt = s_r.cnt - 8'h01;
            end
            else
            begin
                // Single slope; past a lowered TOP it runs to MAX and wraps
                s_nxt.cntDown = 1'b0;
                s_nxt.cnt     = atTop ? TMR8_BOTTOM : s_r.cnt + 8'h01;
            end

            // Overflow flag per mode
            if ((isPc && s_r.cntDown && atBot)                      // [R05] [R19]
                || (mode == TMR8_MODE_FP_CMP && atTop)              // [R19]
                || (!isPc && mode != TMR8_MODE_FP_CMP && s_r.cnt == TMR8_MAX))
                s_nxt.ovfFlag = 1'b1;

            if (match)
                s_nxt.matchFlag = 1'b1;                             // [R11]

            // Double buffer reloads at TOP in PWM modes
            if (isPwm && atTop)
                s_nxt.ocrAct = s_r.ocrBuf;                          // [R18]

            // Compare output waveform
            if (!isPwm)
            begin
                if (match && s_r.com == 2'b01)
                    s_nxt.oc = ~s_r.oc;                             // [R13]
                else if (match && s_r.com[1])
                    s_nxt.oc = s_r.com[0];                          // [R13]
            end
            else if (s_r.com == 2'b01)
            begin
                if (match && s_r.wgmHigh)
                    s_nxt.oc = ~s_r.oc;                             // [R06]
            end
            else if (s_r.com[1] && isFast)
            begin
                if (atTop)
                    s_nxt.oc = ~s_r.com[0];                         // [R14] [R15]
                else if (match && s_r.ocrAct != top)
                    s_nxt.oc = s_r.com[0];                          // [R14]
            end
            else if (s_r.com[1])
            begin
                if (s_r.ocrAct == top)
                begin
                    // Match ignored; level taken at TOP gives a steady output
                    if (atTop && !s_r.cntDown)
                        s_nxt.oc = ~s_r.com[0];                     // [R16] [R07]
                end
                else if (match && (!s_r.cntDown || atBot))
                    s_nxt.oc = s_r.com[0];                          // [R03] [R06] [R07]
                else if (match)
                    s_nxt.oc = ~s_r.com[0];                         // [R03]
                else if (s_r.cntDown && atBot)
                    // Start each up slope from the down-match level
                    s_nxt.oc = ~s_r.com[0];                         // [R08]
            end
        end

        // Register writes in the data phase
        if (busWr)
        begin
            case (s_r.apIdx)
                TMR8_IDX_CTRLA:
                begin
                    s_nxt.com    = wd[TMR8_CTRLA_COM_LO +: 2];
                    s_nxt.wgmLow = wd[TMR8_CTRLA_WGM_LO +: 2];
                end
                TMR8_IDX_CTRLB:
                begin
                    s_nxt.wgmHigh = wd[TMR8_CTRLB_WGM_HI];          // [R21]
                    s_nxt.clkSel  = wd[TMR8_CTRLB_CS_LO +: 3];      // [R10]
                end
                TMR8_IDX_COUNT:
                begin
                    // Software write beats the tick and hides the next match
                    s_nxt.cnt        = wd;
                    s_nxt.blockMatch = 1'b1;
                end
                TMR8_IDX_CMPA:
                begin
                    s_nxt.ocrBuf = wd;
                    if (!isPwm)
                        s_nxt.ocrAct = wd;                          // [R18]
                end
                TMR8_IDX_PIN:
                begin
                    s_nxt.pinData = wd[TMR8_PIN_DATA];
                    s_nxt.pinDir  = wd[TMR8_PIN_DIR];
                end
                default:
                begin
                end
            endcase
        end

        // Address phase capture; read data taken from current state
        s_nxt.apValid = hsel && htrans[1] && hready;
        s_nxt.apWrite = hwrite;
        s_nxt.apIdx   = (haddr[31:10] == 22'h000000) ? haddr[9:2] : 8'h00;
        if (hsel && htrans[1] && hready && !hwrite)
            s_nxt.rdata = readReg(s_nxt.apIdx, s_r);

        // Pin takeover from the output mode
        connected = (s_nxt.com != 2'b00)
                    && !((s_nxt.wgmLow[0] || s_nxt.wgmLow[1]) && s_nxt.wgmLow != 2'b10
                         && s_nxt.com == 2'b01 && !s_nxt.wgmHigh);  // [R12] [R06]
        s_nxt.pinOut = connected ? s_nxt.oc : s_nxt.pinData;        // [R12]
    end

    // ************************************************
    // Registers
    // ************************************************

    // Whole state in one register; reset clears everything
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            s_r <= '0;
        else
            s_r <= s_nxt;
    end

    // ************************************************
    // Outputs
    // ************************************************

    // Zero wait states, so the slave is always ready
    // Read data comes from a flop, so a read right after a
    // write to the same register shows the old value.
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = s_r.rdata;
    assign pin.out   = s_r.pinOut;
    assign pin.oe    = s_r.pinDir;                                  // [R12]

endmodule : tmr8_wave_timer

// ---- tmr8_wave_timer_sva.sv ----
// Purpose: Bus read-back and pin-enable properties of the waveform timer.
// Assumes: Zero-wait bus; read data captured in the address phase.
// Notes:   Bound from the bench top; sees only the timer's ports.
`timescale 1ns/100ps
module tmr8_wave_timer_sva
    import tmr8_pkg::*;
(
    input wire logic        clk,       // Clock
    input wire logic        reset,     // Async reset
    input wire logic        hsel,      // Select
    input wire logic [31:0] haddr,     // Address
    input wire logic [1:0]  htrans,    // Transfer type
    input wire logic        hwrite,    // Write
    input wire logic [2:0]  hsize,     // Size
    input wire logic        hready,    // Ready in
    input wire logic [31:0] hwdata,    // Write data
    input wire logic [31:0] hrdata,    // Read data
    input wire logic        hreadyout, // Ready out
    input wire logic        hresp,     // Response
    input wire tmr8_pin_t   pin        // Pin
);
    // ****************
    // Helpers
    // ****************
    logic       rdTake;
    logic       pinWr;
    logic [2:0] pinWrD_r;
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    // Accepted address phases
    assign rdTake = hsel && htrans[1] && hready && !hwrite;
    assign pinWr = hsel && htrans[1] && hready && hwrite && haddr == 32'h0000_00A0;
    // Age of a pin control write, so an enable change can be traced to it
    always_ff @(posedge clk or posedge reset)
        if (reset)
            pinWrD_r <= 3'h0;
        else
            pinWrD_r <= {pinWrD_r[1:0], pinWr};
    property oeFollow;
        logic v;
        pinWr ##1 (1'b1, v = hwdata[1]) |-> ##[1:2] pin.oe == v;
    endproperty
    // ****************
    // Assertions
    // ****************
    a_ctrla_gaps:
        assert property (rdTake && haddr == 32'h0000_0090 |=> hrdata[31:8] == 24'h0 && hrdata[5:2] == 4'h0)
        else $error("Control A unused bits not zero");
    a_ctrlb_upper:
        assert property (rdTake && haddr == 32'h0000_0094 |=> hrdata[31:4] == 28'h0)
        else $error("Control B upper bits not zero");
    a_flags_upper:
        assert property (rdTake && haddr == 32'h0000_0054 |=> hrdata[31:2] == 30'h0)
        else $error("Flag register unused bits not zero");
    a_unmapped_zero:
        assert property (rdTake && haddr[31:10] != 22'h0 |=> hrdata == 32'h0)
        else $error("Unmapped read not zero");
    a_oe_follows:
        assert property (oeFollow) else $error("Pin enable does not follow direction bit");
    a_oe_only_write:
        assert property ($changed(pin.oe) |-> pinWrD_r[1] || pinWrD_r[2])
        else $error("Pin enable changed without a write");
    a_resp_okay:
        assert property (hresp == 1'b0) else $error("Response not OKAY");
    a_ready_high:
        assert property (hreadyout == 1'b1 [*2]) else $error("Ready out dropped");
    c_pin_write: cover property (pinWr);
    c_pin_rise: cover property ($rose(pin.out) && pin.oe);
    c_flag_read: cover property (rdTake && haddr == 32'h0000_0054);
endmodule : tmr8_wave_timer_sva

// ---- tmr8_pin_load.sv ----
// Purpose: External load on the compare pin.
// Assumes: No pull on the net.
// Notes:   Undriven pad wanders so a stale level never passes.
`timescale 1ns/100ps
module tmr8_pin_load
    import tmr8_pkg::*;
(
    input  wire logic      clk,      // Clock
    input  wire logic      reset,    // Async reset
    input  wire tmr8_pin_t pin,      // Pin from the timer
    output logic           padLevel  // Level at the load
);
    logic lastLevel_r;
    // Remember the pad level for the floating case
    always_ff @(posedge clk or posedge reset)
        if (reset)
            lastLevel_r <= 1'b0;
        else
            lastLevel_r <= padLevel;
    // Released pad shows inverse of last level, changing every cycle
    assign padLevel = pin.oe ? pin.out : ~lastLevel_r;
endmodule : tmr8_pin_load

// ---- timer8_waveform_mode_control_tb_top.sv ----
// Purpose: Self-checking bench for the 8-bit waveform timer.
// Assumes: Zero-wait bus; one idle cycle between transfers.
// Notes:   Pulse widths are counted at the load in clock cycles.
`timescale 1ns/100ps
module timer8_waveform_mode_control_tb_top;
    import tmr8_pkg::*;
    logic        clk, reset, hsel, hwrite, hreadyout, hresp, padLevel;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0]  htrans;
    tmr8_pin_t   pin;
    int          error_cnt, tests_run, hi, lo, x;
    tmr8_wave_timer u_tmr8_wave_timer (.clk(clk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .pin(pin));
    tmr8_pin_load u_tmr8_pin_load (.clk(clk), .reset(reset), .pin(pin), .padLevel(padLevel));
    // ****************
    // Bus and check tasks
    // ****************
    task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] d);
        @(posedge clk);
        hsel <= 1'b1; haddr <= a; htrans <= 2'h2; hwrite <= w;
        do @(posedge clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : xfer
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    // Cycles until the pad shows level v, bounded
    task automatic run_until(input logic v, output int c);
        c = 0;
        while (padLevel !== v && c < 20000)
        begin
            @(posedge clk);
            c++;
        end
    endtask : run_until
    // Stop, load compare in normal mode so it lands at once, then start
    task automatic setup(input logic [7:0] ca, input logic [7:0] cmp, input logic [7:0] cb);
        xfer(32'h94, 1, 32'h0);
        xfer(32'h90, 1, 32'h0);
        xfer(32'h9C, 1, {24'h0, cmp});
        xfer(32'h98, 1, 32'h0);
        xfer(32'h90, 1, {24'h0, ca});
        xfer(32'h94, 1, {24'h0, cb});
    endtask : setup
    // Skip the partial wave, then one high and one low width
    task automatic wave(input logic [7:0] ca, input logic [7:0] cmp, input logic [7:0] cb, input int eh, input int el);
        setup(ca, cmp, cb);
        run_until(1'b0, x);
        run_until(1'b1, x);
        run_until(1'b0, hi);
        run_until(1'b1, lo);
        chk("high width", hi, eh);
        chk("low width", lo, el);
    endtask : wave
    task automatic steady(input logic [7:0] cmp, input logic v);
        setup(8'h81, cmp, 8'h01);
        repeat (600) @(posedge clk);
        x = 0;
        repeat (520)
        begin
            @(posedge clk);
            if (padLevel !== v) x++;
        end
        chk("steady level", x, 0);
    endtask : steady
    // ****************
    // Scenarios
    // ****************
    task automatic t_regs();
        logic [31:0] adr [6] = '{32'h90, 32'h94, 32'h98, 32'h9C, 32'h54, 32'hA0};
        foreach (adr[i])
        begin
            xfer(adr[i], 0, 32'h0);
            chk("reset value", rd, 32'h0);
        end
        xfer(32'h90, 1, 32'hFF);
        xfer(32'h90, 0, 32'h0);
        chk("control A", rd, 32'hC3);
        xfer(32'h94, 1, 32'hF8);
        xfer(32'h94, 0, 32'h0);
        chk("control B", rd, 32'h08);
        xfer(32'h400, 0, 32'h0);
        chk("unmapped", rd, 32'h0);
        xfer(32'hA0, 1, 32'h2);
        @(negedge clk);
        chk("pin enable", pin.oe, 1'b1);
    endtask : t_regs
    task automatic t_phase();
        wave(8'h81, 8'h80, 8'h01, 256, 254);
        chk("period", hi + lo, 510);
        xfer(32'h54, 1, 32'h3);
        repeat (520) @(posedge clk);
        xfer(32'h54, 0, 32'h0);
        chk("overflow at bottom", rd[0], 1'b1);
        wave(8'hC1, 8'h80, 8'h01, 254, 256);
        wave(8'h81, 8'h80, 8'h02, 2048, 2032);
    endtask : t_phase
    task automatic t_other();
        steady(8'h00, 1'b0);
        steady(8'hFF, 1'b1);
        wave(8'h42, 8'h09, 8'h01, 10, 10);
        wave(8'h83, 8'h3F, 8'h01, 64, 192);
    endtask : t_other
    task automatic print_verdict();
        $display("Checks %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : print_verdict
    // ****************
    // Clock, reset, run
    // ****************
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // Whole run is under 20000 cycles; cut a hang at 60000
    initial
    begin
        #300000;
        error_cnt++;
        print_verdict();
    end
    initial
    begin
        error_cnt = 0; tests_run = 0; reset = 1'b1;
        hsel = 1'b0; haddr = 32'h0; htrans = 2'h0; hwrite = 1'b0; hwdata = 32'h0;
        repeat (16) @(posedge clk);
        reset <= 1'b0;
        t_regs();
        t_phase();
        t_other();
        print_verdict();
    end
endmodule : timer8_waveform_mode_control_tb_top
bind tmr8_wave_timer tmr8_wave_timer_sva u_tmr8_wave_timer_sva (.clk(clk), .reset(reset), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready), .hwdata(hwdata),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .pin(pin));
